// file: rqp_engine_model.sv
/*
 * Behavioural model of the MAC bus-master engine beside the queue pointers:
 * issues descriptor reads and status writes on command, promptly or slowly.
 * Assumes a bench that pulses GO for one cycle with NUM, GAP and STS_SEL set.
 */
`timescale 1ns/100ps
`default_nettype none

module rqp_engine_model (
    input  wire logic        MCLK,        // system clock
    input  wire logic        RST_B,       // chip reset, async low
    input  wire logic        GO,          // start a burst of entries
    input  wire logic        STS_SEL,     // burst is status writes
    input  wire logic [7:0]  NUM,         // entries in the burst
    input  wire logic [3:0]  GAP,         // stall cycles between entries
    input  wire logic        FETCH_OK,    // design allows a fetch
    input  wire logic        RX_ACTIVE,   // channel running
    input  wire logic [31:0] DESC_ADDR,   // descriptor fetch pointer
    output var  logic        DESC_DONE,   // one descriptor read
    output var  logic        STS_DONE,    // one status written
    output var  logic        BUF_ADDR_LD, // data pointer update
    output var  logic [31:0] BUF_ADDR,    // new data pointer
    output var  logic        BUSY         // burst not finished
);
    logic [7:0] left;
    logic [3:0] wait_c;
    logic       sts;

    assign BUSY = (left != 8'h00);

    // one entry per step; no fetch while a previous pulse is still in flight,
    // since the count it lowers is not yet visible on FETCH_OK
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            left        <= 8'h00;
            wait_c      <= 4'h0;
            sts         <= 1'b0;
            DESC_DONE   <= 1'b0;
            STS_DONE    <= 1'b0;
            BUF_ADDR_LD <= 1'b0;
            BUF_ADDR    <= 32'h00000000;
        end else begin
            DESC_DONE   <= 1'b0;
            STS_DONE    <= 1'b0;
            BUF_ADDR_LD <= 1'b0;
            BUF_ADDR    <= ~BUF_ADDR;                 // released bus toggles every cycle instead of holding its value
            if (GO) begin
                left   <= NUM;
                sts    <= STS_SEL;
                wait_c <= GAP;
            end else if (BUSY && RX_ACTIVE) begin
                if (wait_c != 4'h0) begin
                    wait_c <= wait_c - 4'h1;
                end else if (sts) begin
                    STS_DONE <= 1'b1;
                    left     <= left - 8'h01;
                    wait_c   <= GAP;
                end else if (FETCH_OK && !DESC_DONE) begin
                    DESC_DONE   <= 1'b1;
                    BUF_ADDR_LD <= 1'b1;
                    BUF_ADDR    <= DESC_ADDR + 32'h00000100;
                    left        <= left - 8'h01;
                    wait_c      <= GAP;
                end
            end
        end
    end
endmodule : rqp_engine_model

`default_nettype wire

// file: rqp_pkg.sv
/*
 * Package for the receive descriptor queue pointer block: register map, field
 * positions, reset values and the state types shared by the pointer logic.
 * Assumes a 32-bit APB with the block decoded on a 10-bit byte address.
 */
`default_nettype none

package rqp_pkg;

    // ------------------------------------------------------------------
    // register map: printed offsets are word indices, byte address = 4x
    // ------------------------------------------------------------------
    localparam int          ADDR_W       = 10;
    localparam logic [31:0] IDX_BASE     = 32'h80010080;  // index of first word in the window
    localparam logic [31:0] IDX_BUF_CUR  = 32'h80010088;
    localparam logic [31:0] IDX_DQ_BASE  = 32'h80010090;
    localparam logic [31:0] IDX_DQ_LEN   = 32'h80010094;
    localparam logic [31:0] IDX_DQ_REM   = 32'h80010096;
    localparam logic [31:0] IDX_DQ_CUR   = 32'h80010098;
    localparam logic [31:0] IDX_DQ_ENQ   = 32'h8001009c;
    localparam logic [31:0] IDX_SQ_BASE  = 32'h800100a0;
    localparam logic [31:0] IDX_SQ_LEN   = 32'h800100a4;
    localparam logic [31:0] IDX_SQ_REM   = 32'h800100a6;
    localparam logic [31:0] IDX_SQ_CUR   = 32'h800100a8;
    localparam logic [31:0] IDX_SQ_ENQ   = 32'h800100ac;
    localparam logic [31:0] IDX_CTRL     = 32'h800100c0;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [31:0] idx);
        logic [31:0] off;
        off = (idx - IDX_BASE) << 2;
        return off[ADDR_W-1:0];
    endfunction : byte_addr

    localparam logic [ADDR_W-1:0] ADR_BUF_CUR = byte_addr(IDX_BUF_CUR);
    localparam logic [ADDR_W-1:0] ADR_DQ_BASE = byte_addr(IDX_DQ_BASE);
    localparam logic [ADDR_W-1:0] ADR_DQ_LEN  = byte_addr(IDX_DQ_LEN);
    localparam logic [ADDR_W-1:0] ADR_DQ_REM  = byte_addr(IDX_DQ_REM);
    localparam logic [ADDR_W-1:0] ADR_DQ_CUR  = byte_addr(IDX_DQ_CUR);
    localparam logic [ADDR_W-1:0] ADR_DQ_ENQ  = byte_addr(IDX_DQ_ENQ);
    localparam logic [ADDR_W-1:0] ADR_SQ_BASE = byte_addr(IDX_SQ_BASE);
    localparam logic [ADDR_W-1:0] ADR_SQ_LEN  = byte_addr(IDX_SQ_LEN);
    localparam logic [ADDR_W-1:0] ADR_SQ_REM  = byte_addr(IDX_SQ_REM);
    localparam logic [ADDR_W-1:0] ADR_SQ_CUR  = byte_addr(IDX_SQ_CUR);
    localparam logic [ADDR_W-1:0] ADR_SQ_ENQ  = byte_addr(IDX_SQ_ENQ);
    localparam logic [ADDR_W-1:0] ADR_CTRL    = byte_addr(IDX_CTRL);

    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    localparam int          ENQ_VAL_LSB  = 16;            // count sits in bits 31:16
    localparam int          ENQ_INC_W    = 8;             // increment field bits 7:0
    localparam int          CTRL_EN_BIT  = 0;             // receive_enable_command
    localparam int          CTRL_DIS_BIT = 1;             // receive disable
    localparam int          CTRL_CHR_BIT = 2;             // receive channel reset
    localparam int          CTRL_ACT_BIT = 8;             // read: channel active
    localparam int          CTRL_INI_BIT = 9;             // read: channel initialised
    localparam logic [31:0] RST_WORD     = 32'h00000000;
    localparam logic [15:0] RST_HALF     = 16'h0000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {RQP_IDLE, RQP_INIT, RQP_RUN} rqp_state_t;

    typedef struct packed {
        logic [31:0] addr;   // current pointer
        logic [15:0] rem;    // bytes left to the queue end
    } rqp_ring_t;

    typedef struct packed {
        rqp_state_t  st;
        logic        inited;
        logic [31:0] buf_addr;
        logic [31:0] dq_base;
        logic [15:0] dq_len;
        rqp_ring_t   dq;
        logic [15:0] dq_cnt;
        logic [31:0] sq_base;
        logic [15:0] sq_len;
        rqp_ring_t   sq;
        logic [15:0] sq_cnt;
        logic [31:0] rdata;
    } rqp_regs_t;

endpackage : rqp_pkg

`default_nettype wire

// file: rqp_ring_step.sv
/*
 * One step of a circular queue pointer: advances the pointer and the
 * remaining length by one entry, or wraps both to the programmed queue.
 * Assumes the caller only uses the result when an entry was consumed.
 */
`timescale 1ns/100ps
`default_nettype none

module rqp_ring_step (
    input  wire logic [31:0]       BASE,   // programmed queue base
    input  wire logic [15:0]       LEN,    // programmed queue length
    input  wire logic [15:0]       STEP,   // entry size in bytes
    input  wire rqp_pkg::rqp_ring_t CUR,   // pointer now
    output var  rqp_pkg::rqp_ring_t NXT,   // pointer after one entry
    output var  logic              WRAP    // this entry was the last one
);
    import rqp_pkg::*;

    // ------------------------------------------------------------------
    // advance or wrap
    // ------------------------------------------------------------------
    // compare on remaining bytes, not on addresses, so a base near the top
    // of memory cannot fool the end test through address roll-over
    always_comb begin
        WRAP = (CUR.rem <= STEP);
        if (WRAP) begin
            NXT.addr = BASE;
            NXT.rem  = LEN;
        end else begin
            NXT.addr = CUR.addr + {16'h0000, STEP};
            NXT.rem  = CUR.rem - STEP;
        end
    end

endmodule : rqp_ring_step

`default_nettype wire

// file: rqp_top.sv
/*
 * Receive descriptor and status queue pointers with their APB register file.
 * Assumes the MAC's bus-master engine reports each finished descriptor read
 * and status write with a one-cycle pulse on MCLK.
 */
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rqp_top #(
    parameter logic [15:0] DESC_BYTES = 16'h0008,   // descriptor size
    parameter logic [15:0] STS_BYTES  = 16'h0008    // status entry size
) (
    input  wire logic                       MCLK,         // 25 MHz clock
    input  wire logic                       RST_B,        // chip reset, async low
    input  wire logic                       PSEL,         // apb select
    input  wire logic                       PENABLE,      // apb access phase
    input  wire logic                       PWRITE,       // apb direction
    input  wire logic [rqp_pkg::ADDR_W-1:0] PADDR,        // apb byte address
    input  wire logic [31:0]                PWDATA,       // apb write data
    output var  logic [31:0]                PRDATA,       // apb read data
    output var  logic                       PREADY,       // apb ready
    output var  logic                       PSLVERR,      // unmapped address
    input  wire logic                       DESC_DONE,    // one descriptor read
    input  wire logic                       STS_DONE,     // one status written
    input  wire logic                       BUF_ADDR_LD,  // data pointer update
    input  wire logic [31:0]                BUF_ADDR,     // new data pointer
    output var  logic                       FETCH_OK,     // may fetch descriptor
    output var  logic [31:0]                DESC_ADDR,    // next descriptor addr
    output var  logic [31:0]                STS_ADDR,     // next status addr
    output var  logic [31:0]                RX_BUF_ADDR,  // data write pointer
    output var  logic                       RX_ACTIVE     // channel running
);
    import rqp_pkg::*;

    rqp_regs_t   st_r;
    rqp_regs_t   st_nxt;
    rqp_ring_t   dq_step;
    rqp_ring_t   sq_step;
    logic        dq_wrap;
    logic        sq_wrap;
    logic        mapped;
    logic        setup;
    logic        wr;
    logic [31:0] rd_mux;
    logic        desc_ev;
    logic        sts_ev;
    logic [15:0] dq_inc;
    logic [15:0] sq_inc;

    // ------------------------------------------------------------------
    // pointer steppers
    // ------------------------------------------------------------------
    rqp_ring_step u_dq_step (
        .BASE (st_r.dq_base),
        .LEN  (st_r.dq_len),
        .STEP (DESC_BYTES),
        .CUR  (st_r.dq),
        .NXT  (dq_step),
        .WRAP (dq_wrap)
    );

    rqp_ring_step u_sq_step (
        .BASE (st_r.sq_base),
        .LEN  (st_r.sq_len),
        .STEP (STS_BYTES),
        .CUR  (st_r.sq),
        .NXT  (sq_step),
        .WRAP (sq_wrap)
    );

    // ------------------------------------------------------------------
    // apb decode and read mux
    // ------------------------------------------------------------------
    // zero wait states: read data is captured in the setup cycle
    assign setup   = PSEL & ~PENABLE;
    assign wr      = PSEL & PENABLE & PWRITE & mapped;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign dq_inc  = {8'h00, PWDATA[ENQ_INC_W-1:0]};
    assign sq_inc  = {8'h00, PWDATA[ENQ_INC_W-1:0]};
    // descriptor and status pulses count only while the channel runs
    assign desc_ev = DESC_DONE & (st_r.st == RQP_RUN);
    assign sts_ev  = STS_DONE & (st_r.st == RQP_RUN);

    // length and remaining half-words read in the low lanes, counts in the high lanes, other bits zero
    always_comb begin
        mapped = 1'b1;
        rd_mux = RST_WORD;
        unique case (PADDR)
            ADR_BUF_CUR: rd_mux = st_r.buf_addr;
            ADR_DQ_BASE: rd_mux = st_r.dq_base;
            ADR_DQ_LEN:  rd_mux = {16'h0000, st_r.dq_len};
            ADR_DQ_REM:  rd_mux = {16'h0000, st_r.dq.rem};
            ADR_DQ_CUR:  rd_mux = st_r.dq.addr;
            ADR_DQ_ENQ:  rd_mux = {st_r.dq_cnt, 16'h0000};
            ADR_SQ_BASE: rd_mux = st_r.sq_base;
            ADR_SQ_LEN:  rd_mux = {16'h0000, st_r.sq_len};
            ADR_SQ_REM:  rd_mux = {16'h0000, st_r.sq.rem};
            ADR_SQ_CUR:  rd_mux = st_r.sq.addr;
            ADR_SQ_ENQ:  rd_mux = {st_r.sq_cnt, 16'h0000};
            ADR_CTRL: begin
                rd_mux[CTRL_ACT_BIT] = (st_r.st == RQP_RUN);
                rd_mux[CTRL_INI_BIT] = st_r.inited;
            end
            default:     mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // engine updates first, host writes after so software has the last
    // word on pointer registers; counts take both so no event is lost
    always_comb begin
        st_nxt = st_r;
        if (setup) begin
            st_nxt.rdata = rd_mux;
        end
        if (BUF_ADDR_LD) begin
            st_nxt.buf_addr = BUF_ADDR;
        end
        if (desc_ev) begin
            st_nxt.dq     = dq_step;
            st_nxt.dq_cnt = st_r.dq_cnt - 16'h0001;
        end
        if (sts_ev) begin
            st_nxt.sq     = sq_step;
            st_nxt.sq_cnt = st_r.sq_cnt - 16'h0001;
        end
        unique case (st_r.st)
            RQP_IDLE: begin
                if (wr && PADDR == ADR_CTRL && PWDATA[CTRL_EN_BIT]) begin
                    st_nxt.st = st_r.inited ? RQP_RUN : RQP_INIT;
                end
            end
            RQP_INIT: begin
                // endpoints from base, length and the start set by software
                st_nxt.dq_cnt = RST_HALF;
                st_nxt.sq_cnt = RST_HALF;
                st_nxt.dq.rem = 16'(st_r.dq_base + {16'h0000, st_r.dq_len}
                                    - st_r.dq.addr);
                st_nxt.sq.rem = 16'(st_r.sq_base + {16'h0000, st_r.sq_len}
                                    - st_r.sq.addr);
                st_nxt.inited = 1'b1;
                st_nxt.st     = RQP_RUN;
            end
            RQP_RUN: begin
                if (wr && PADDR == ADR_CTRL && PWDATA[CTRL_DIS_BIT]) begin
                    st_nxt.st = RQP_IDLE;
                end
            end
        endcase
        if (wr) begin
            unique case (PADDR)
                ADR_BUF_CUR: st_nxt.buf_addr = PWDATA;
                ADR_DQ_BASE: st_nxt.dq_base  = PWDATA;
                ADR_DQ_LEN:  st_nxt.dq_len   = PWDATA[15:0];
                ADR_DQ_REM:  st_nxt.dq.rem   = PWDATA[15:0];
                ADR_DQ_CUR:  st_nxt.dq.addr  = PWDATA;
                ADR_DQ_ENQ:  st_nxt.dq_cnt   = st_nxt.dq_cnt + dq_inc;
                ADR_SQ_BASE: st_nxt.sq_base  = PWDATA;
                ADR_SQ_LEN:  st_nxt.sq_len   = PWDATA[15:0];
                ADR_SQ_REM:  st_nxt.sq.rem   = PWDATA[15:0];
                ADR_SQ_CUR:  st_nxt.sq.addr  = PWDATA;
                ADR_SQ_ENQ:  st_nxt.sq_cnt   = st_nxt.sq_cnt + sq_inc;
                ADR_CTRL: begin
                    // channel reset beats enable in the same write
                    if (PWDATA[CTRL_CHR_BIT]) begin
                        st_nxt.st     = RQP_IDLE;
                        st_nxt.inited = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // chip reset clears all; channel reset clears only st and inited, through the next-state logic
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // the pointer may run ahead of the descriptor in use by the engine
    assign FETCH_OK    = (st_r.st == RQP_RUN) && (st_r.dq_cnt != RST_HALF);
    assign DESC_ADDR   = st_r.dq.addr;
    assign STS_ADDR    = st_r.sq.addr;
    assign RX_BUF_ADDR = st_r.buf_addr;
    assign RX_ACTIVE   = (st_r.st == RQP_RUN);
    assign PRDATA      = st_r.rdata;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    logic wr_dq_ptr;
    logic wr_sq_ptr;
    logic wr_dq_enq;
    assign wr_dq_ptr = wr && (PADDR == ADR_DQ_CUR || PADDR == ADR_DQ_REM);
    assign wr_sq_ptr = wr && (PADDR == ADR_SQ_CUR || PADDR == ADR_SQ_REM);
    assign wr_dq_enq = wr && (PADDR == ADR_DQ_ENQ);

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    fetch_gate_a: assert property (desc_ev && st_r.dq_cnt == 16'h0001 && !wr_dq_enq |=>
        !FETCH_OK)
        else $error("fetch still allowed after last valid descriptor");
    desc_wrap_a: assert property (desc_ev && dq_wrap && !wr_dq_ptr |=>
        DESC_ADDR == $past(st_r.dq_base) && st_r.dq.rem == $past(st_r.dq_len))
        else $error("descriptor pointer did not wrap to base");
    desc_adv_a: assert property (desc_ev && !dq_wrap && !wr_dq_ptr |=>
        DESC_ADDR == $past(DESC_ADDR) + {16'h0000, DESC_BYTES})
        else $error("descriptor pointer did not advance");
    rem_track_a: assert property (desc_ev && !dq_wrap && !wr_dq_ptr |=>
        st_r.dq.rem == $past(st_r.dq.rem) - DESC_BYTES)
        else $error("remaining length not reduced by one entry");
    sts_wrap_a: assert property (sts_ev && sq_wrap && !wr_sq_ptr |=>
        STS_ADDR == $past(st_r.sq_base))
        else $error("status pointer did not wrap to base");
    enq_add_a: assert property (wr_dq_enq && !desc_ev && st_r.st != RQP_INIT |=>
        st_r.dq_cnt == $past(st_r.dq_cnt) + {8'h00, $past(PWDATA[7:0])})
        else $error("increment not added to valid count");
    enq_sub_a: assert property (desc_ev && !wr_dq_enq |=>
        st_r.dq_cnt == $past(st_r.dq_cnt) - 16'h0001)
        else $error("valid count not reduced after descriptor read");
    init_clear_a: assert property (st_r.st == RQP_INIT && !wr |=>
        st_r.dq_cnt == 16'h0000 && st_r.sq_cnt == 16'h0000 && RX_ACTIVE)
        else $error("initialisation did not clear counts");
    buf_load_a: assert property (BUF_ADDR_LD && !(wr && PADDR == ADR_BUF_CUR)
        |=> RX_BUF_ADDR == $past(BUF_ADDR))
        else $error("data write pointer not updated");

endmodule : rqp_top

`default_nettype wire

// file: rqp_top_tb.sv
/*
 * Self-checking bench for the receive queue pointers: APB register access,
 * descriptor and status queue walks with wraps, valid count, channel init.
 * Assumes zero-wait APB and the engine model in rqp_engine_model.sv.
 */
`timescale 1ns/100ps
`default_nettype none

module rqp_top_tb;
    import rqp_pkg::*;

    logic        mclk, rst_b, psel, penable, pwrite, pslverr, pready;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        desc_done, sts_done, buf_ld, fetch_ok, rx_active;
    logic [31:0] buf_addr, desc_addr, sts_addr, rx_buf_addr;
    logic        go, sts_sel, busy, er;
    logic [7:0]  num;
    logic [3:0]  gap;
    int          errors, total_checks;

    rqp_top rqp_top_inst (.MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .DESC_DONE(desc_done), .STS_DONE(sts_done),
        .BUF_ADDR_LD(buf_ld), .BUF_ADDR(buf_addr), .FETCH_OK(fetch_ok),
        .DESC_ADDR(desc_addr), .STS_ADDR(sts_addr), .RX_BUF_ADDR(rx_buf_addr),
        .RX_ACTIVE(rx_active));

    rqp_engine_model rqp_engine_model_inst (.MCLK(mclk), .RST_B(rst_b), .GO(go),
        .STS_SEL(sts_sel), .NUM(num), .GAP(gap), .FETCH_OK(fetch_ok),
        .RX_ACTIVE(rx_active), .DESC_ADDR(desc_addr), .DESC_DONE(desc_done),
        .STS_DONE(sts_done), .BUF_ADDR_LD(buf_ld), .BUF_ADDR(buf_addr), .BUSY(busy));

    // ----------------------------------------------------------------
    // clock, report and compare
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    task automatic chk32(input logic [31:0] exp, input logic [31:0] got, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk32

    // ----------------------------------------------------------------
    // apb master: request held until pready is seen high at an edge
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk32(exp, rd, "register read");
    endtask : rd_chk

    // wait for a level: 0 rx_active, 1 model busy, 2 fetch_ok
    task automatic wait_lvl(input int which, input logic val);
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge mclk);
            if ((which == 0 ? rx_active : which == 1 ? busy : fetch_ok) === val) return;
        end
        errors++;
        test_done();
    endtask : wait_lvl

    // one engine burst, then let the last pulse land
    task automatic run(input logic s, input logic [7:0] n, input logic [3:0] g);
        @(posedge mclk);
        go      <= 1'b1;
        sts_sel <= s;
        num     <= n;
        gap     <= g;
        @(posedge mclk);
        go <= 1'b0;
        wait_lvl(1, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
    endtask : run

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 10'h000; pwdata = 32'h00000000; go = 1'b0; sts_sel = 1'b0;
        num = 8'h00; gap = 4'h0; errors = 0; total_checks = 0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        // chip reset clears the descriptor base, pointer and count and the buffer pointer
        rd_chk(ADR_DQ_BASE, RST_WORD);
        rd_chk(ADR_DQ_CUR, RST_WORD);
        rd_chk(ADR_DQ_ENQ, RST_WORD);
        rd_chk(ADR_BUF_CUR, RST_WORD);
        // host set-up: aligned bases, whole lengths, start entry, rem left alone
        apb(1'b1, ADR_DQ_BASE, 32'h00001000);
        apb(1'b1, ADR_DQ_LEN, 32'hffff0018);
        apb(1'b1, ADR_DQ_CUR, 32'h00001000);
        apb(1'b1, ADR_SQ_BASE, 32'h00002000);
        apb(1'b1, ADR_SQ_LEN, 32'h00000010);
        apb(1'b1, ADR_SQ_CUR, 32'h00002000);
        rd_chk(ADR_DQ_LEN, 32'h00000018);
        apb(1'b0, 10'h3fc, 32'h00000000);
        chk32(32'h00000001, {31'h0, er}, "unmapped error flag");
        chk32(32'h00000000, rd, "unmapped read");
        apb(1'b1, ADR_CTRL, 32'h00000001);
        wait_lvl(0, 1'b1);
        rd_chk(ADR_DQ_REM, 32'h00000018);
        rd_chk(ADR_DQ_ENQ, 32'h00000000);
        chk32(32'h0, {31'h0, fetch_ok}, "fetch allowed");
        // count 3 then 2 more, upper bits of the write ignored
        apb(1'b1, ADR_DQ_ENQ, 32'h00000003);
        apb(1'b1, ADR_DQ_ENQ, 32'hffff0002);
        rd_chk(ADR_DQ_ENQ, 32'h00050000);
        // three slow fetches walk the queue and wrap to the base
        run(1'b0, 8'h03, 4'h2);
        chk32(32'h00001000, desc_addr, "desc pointer");
        rd_chk(ADR_DQ_CUR, 32'h00001000);
        rd_chk(ADR_DQ_REM, 32'h00000018);
        rd_chk(ADR_DQ_ENQ, 32'h00020000);
        rd_chk(ADR_BUF_CUR, 32'h00001110);
        chk32(32'h00001110, rx_buf_addr, "buffer pointer");
        // ask for four with only two valid: engine must stall
        @(posedge mclk);
        go <= 1'b1; sts_sel <= 1'b0; num <= 8'h04; gap <= 4'h0;
        @(posedge mclk);
        go <= 1'b0;
        wait_lvl(2, 1'b0);
        repeat (4) @(posedge mclk);
        #1;
        chk32(32'h00001010, desc_addr, "desc pointer");
        rd_chk(ADR_DQ_REM, 32'h00000008);
        rd_chk(ADR_DQ_ENQ, 32'h00000000);
        run(1'b0, 8'h00, 4'h0);
        // three prompt status writes wrap a two-entry status queue
        run(1'b1, 8'h03, 4'h0);
        chk32(32'h00002008, sts_addr, "status pointer");
        // re-enable keeps counts; channel reset forces a fresh init
        apb(1'b1, ADR_DQ_ENQ, 32'h00000001);
        apb(1'b1, ADR_CTRL, 32'h00000002);
        wait_lvl(0, 1'b0);
        apb(1'b1, ADR_CTRL, 32'h00000001);
        wait_lvl(0, 1'b1);
        rd_chk(ADR_DQ_ENQ, 32'h00010000);
        apb(1'b1, ADR_CTRL, 32'h00000004);
        apb(1'b1, ADR_DQ_CUR, 32'h00001008);
        apb(1'b1, ADR_CTRL, 32'h00000001);
        wait_lvl(0, 1'b1);
        rd_chk(ADR_DQ_ENQ, 32'h00000000);
        rd_chk(ADR_DQ_REM, 32'h00000010);
        test_done();
    end
endmodule : rqp_top_tb

`default_nettype wire
